// >>> hdl/flash_host_pkg.sv
// package of the flash host controller: op codes, pin and request carriers, timing counts
// assumes a 40 MHz system clock and an external byte-wide parallel flash on plain pins
package flash_host_pkg;

   // ==========================================================================
   // timing
   localparam int CLK_NS = 25;
   localparam int T_SETUP_NS = 25;
   localparam int T_STROBE_NS = 50;
   localparam int T_ACCESS_NS = 75;
   localparam int T_GAP_NS = 25;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int SECT_WIN_US = 50;
   localparam int SECT_WIN_CYC = SECT_WIN_US * 1000 / CLK_NS;
   localparam int WIN_W = 11;

   // ==========================================================================
   // command addresses and bytes
   localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
   localparam logic [18:0] UNLOCK2_ADDR = 19'h002AA;
   localparam logic [18:0] ANY_ADDR = 19'h00000;
   localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
   localparam logic [7:0] UNLOCK2_DATA = 8'h55;
   localparam logic [7:0] PROGRAM_SETUP = 8'hA0;
   localparam logic [7:0] ERASE_SETUP = 8'h80;
   localparam logic [7:0] IDENT_ENTRY = 8'h90;
   localparam logic [7:0] CHIP_ERASE_CMD = 8'h10;
   localparam logic [7:0] SECT_ERASE_CMD = 8'h30;
   localparam logic [7:0] RESET_CMD = 8'hF0;
   localparam logic [7:0] SUSPEND_CMD = 8'hB0;
   localparam logic [7:0] RESUME_CMD = 8'h30;
   localparam int SECT_LSB = 16;
   localparam int TIME_LIMIT_BIT = 5;
   localparam int TOGGLE_BIT = 6;

   // ==========================================================================
   // types
   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_RESET = 4'h1,
      OP_ID_READ = 4'h2,
      OP_PROGRAM = 4'h3,
      OP_CHIP_ERASE = 4'h4,
      OP_SECT_ERASE = 4'h5,
      OP_SECT_ADD = 4'h6,
      OP_SUSPEND = 4'h7,
      OP_RESUME = 4'h8,
      OP_POLL = 4'h9
   } op_t;

   typedef struct packed {
      op_t op;
      logic [18:0] addr;
      logic [7:0] data;
   } cmd_t;

   typedef struct packed {
      logic wr;
      logic [18:0] addr;
      logic [7:0] data;
   } cyc_req_t;

   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic dq_en_n;
      logic [18:0] addr;
      logic [7:0] dq;
   } flash_pins_t;

endpackage : flash_host_pkg

// >>> hdl/flash_bus_cycle.sv
// single read or write cycle on the flash pins
// assumes one request at a time; data inputs are synchronous to sys_clk_i
`timescale 1ns/1ps
module flash_bus_cycle
   import flash_host_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   input cyc_req_t req_i,
   input wire logic [7:0] fl_dq_i,
   output logic ack_o,
   output logic [7:0] rdata_o,
   output flash_pins_t pins_o
);

   // ==========================================================================
   // cycle sequencer
   typedef enum logic [2:0] {
      B_IDLE = 3'b000,
      B_SETUP = 3'b001,
      B_STROBE = 3'b010,
      B_HOLD = 3'b011,
      B_GAP = 3'b100
   } bus_state_t;

   localparam flash_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_en_n: 1'b1,
                                         addr: 19'h00000, dq: 8'h00};

   bus_state_t state_q;
   logic [2:0] cnt_q;
   logic wr_q;
   wire cnt_done = (cnt_q == 3'h0);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_q <= B_IDLE;
         cnt_q <= 3'h0;
         wr_q <= 1'b0;
         ack_o <= 1'b0;
         rdata_o <= 8'h00;
         pins_o <= PINS_IDLE;
      end else begin
         ack_o <= 1'b0;
         if (!cnt_done) begin
            cnt_q <= cnt_q - 3'h1;
         end
         unique case (state_q)
            B_IDLE: begin
               if (req_valid_i) begin
                  // address and chip select first, strobe later [RL5]
                  wr_q <= req_i.wr;
                  pins_o.addr <= req_i.addr;
                  pins_o.dq <= req_i.data;
                  pins_o.ce_n <= 1'b0;
                  pins_o.dq_en_n <= ~req_i.wr;
                  cnt_q <= 3'(SETUP_CYC - 1);
                  state_q <= B_SETUP;
               end
            end
            B_SETUP: begin
               if (cnt_done) begin
                  // write strobe only with output enable high [RL2]
                  pins_o.we_n <= ~wr_q;
                  pins_o.oe_n <= wr_q;
                  cnt_q <= wr_q ? 3'(STROBE_CYC - 1) : 3'(ACCESS_CYC - 1);
                  state_q <= B_STROBE;
               end
            end
            B_STROBE: begin
               if (cnt_done) begin
                  // write strobe rises first, data still held [RL6]
                  pins_o.we_n <= 1'b1;
                  pins_o.oe_n <= 1'b1;
                  if (!wr_q) begin
                     rdata_o <= fl_dq_i;
                  end
                  state_q <= B_HOLD;
               end
            end
            B_HOLD: begin
               pins_o.ce_n <= 1'b1;
               pins_o.dq_en_n <= 1'b1;
               ack_o <= 1'b1;
               cnt_q <= 3'(GAP_CYC - 1);
               state_q <= B_GAP;
            end
            B_GAP: begin
               if (cnt_done) begin
                  state_q <= B_IDLE;
               end
            end
            default: begin
               state_q <= B_IDLE;
            end
         endcase
      end
   end

endmodule : flash_bus_cycle

// >>> hdl/flash_host_ctrl.sv
// host side command sequencer for a byte-wide parallel flash
// assumes the user holds cmd_i stable while cmd_valid_i is high and cmd_ready_o is low
`timescale 1ns/1ps

// Behaviour
// RL1 - device starts no write cycle with output enable low or a strobe high
// RL2 - host writes by pulling chip select and write strobe low, output enable high
// RL3 - device ignores power-up strobes and starts in read-array mode
// RL4 - device drops a malformed or out-of-order sequence back to read-array
// RL5 - device latches address on the later falling edge of strobe or select
// RL6 - device latches data on the earlier rising edge of strobe or select
// RL7 - in erase suspend, suspended sectors read status, others read array
// RL8 - one reset write at any address returns to read-array
// RL9 - reset aborts an erase sequence; ignored once erasure runs
// RL10 - reset aborts a program sequence; ignored once programming runs
// RL11 - reset aborts autoselect; host must write reset to leave identification
// RL12 - host writes reset when the time-limit bit rises; device returns to array
// RL13 - two unlocks and identification command enter identification mode for reads
// RL14 - identification reads give maker, part and continuation codes by low address
// RL15 - identification read at low address 02h gives sector protect state
// RL16 - byte program is unlock, unlock, setup, then address and data
// RL17 - device ignores commands while programming; any address order allowed
// RL18 - programming never turns a stored zero into a one
// RL19 - chip erase is two unlocks, setup, two unlocks, chip-erase command
// RL20 - device ignores every command during chip erase
// RL21 - host spaces extra sector-erase pairs within the 50 us window
// RL22 - window timed from the final write strobe rise; timer bit shows expiry
// RL23 - other commands in the window discard queued sectors
// RL24 - once sector erasure runs, only erase suspend is accepted
// RL25 - unlock writes AA at 555 then 55 at 2AA, high bits ignored
// RL26 - command bytes A0, 80, 90; sixth cycle 10 chip or 30 at sector
// RL27 - B0 suspends a sector erase, 30 resumes it only when suspended
// RL28 - sector chosen by the three top address bits
// RL29 - device keeps one sequence state register reset on mismatch
module flash_host_ctrl
   import flash_host_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input cmd_t cmd_i,
   output logic cmd_ready_o,
   output logic done_o,
   output logic err_o,
   output logic [7:0] rdata_o,
   output logic window_open_o,
   output logic suspended_o,
   input wire logic [7:0] fl_dq_i,
   output flash_pins_t fl_pins_o
);

   // ==========================================================================
   // state
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ISSUE = 2'b01,
      S_NEXT = 2'b10
   } state_t;

   typedef enum logic [2:0] {
      PH_CMD = 3'b000,
      PH_READ = 3'b001,
      PH_POLL1 = 3'b010,
      PH_POLL2 = 3'b011,
      PH_EXIT = 3'b100
   } phase_t;

   state_t state_q, state_d;
   phase_t phase_q, phase_d;
   logic [2:0] step_q, step_d;
   cmd_t cmd_q;
   logic [7:0] first_q;
   logic fail_q, fail_d;
   logic erase_act_q;
   logic susp_q;
   logic [WIN_W-1:0] win_q;
   logic fin, fin_err;

   // ==========================================================================
   // sequence tables
   function automatic logic [2:0] op_steps(input op_t op);
      unique case (op)
         OP_READ, OP_POLL: op_steps = 3'd0;
         OP_RESET, OP_SECT_ADD, OP_SUSPEND, OP_RESUME: op_steps = 3'd1;
         OP_ID_READ: op_steps = 3'd3;
         OP_PROGRAM: op_steps = 3'd4;
         OP_CHIP_ERASE, OP_SECT_ERASE: op_steps = 3'd6;
         default: op_steps = 3'd0;
      endcase
   endfunction : op_steps

   function automatic cyc_req_t seq_req(input cmd_t c, input logic [2:0] step);
      logic [18:0] sect;
      sect = {c.addr[18:SECT_LSB], 16'h0000};
      seq_req = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA}; // [RL25]
      unique case (c.op)
         OP_RESET: seq_req = '{wr: 1'b1, addr: ANY_ADDR, data: RESET_CMD};
         OP_SUSPEND: seq_req = '{wr: 1'b1, addr: ANY_ADDR, data: SUSPEND_CMD};
         OP_RESUME: seq_req = '{wr: 1'b1, addr: ANY_ADDR, data: RESUME_CMD};
         OP_SECT_ADD: seq_req = '{wr: 1'b1, addr: sect, data: SECT_ERASE_CMD}; // [RL21]
         default: begin
            unique case (step)
               3'd1, 3'd4: seq_req = '{wr: 1'b1, addr: UNLOCK2_ADDR, data: UNLOCK2_DATA}; // [RL25]
               3'd2: seq_req.data = (c.op == OP_PROGRAM) ? PROGRAM_SETUP :
                                    (c.op == OP_ID_READ) ? IDENT_ENTRY : ERASE_SETUP; // [RL26]
               3'd3: if (c.op == OP_PROGRAM) begin
                  seq_req = '{wr: 1'b1, addr: c.addr, data: c.data};
               end
               3'd5: seq_req = (c.op == OP_CHIP_ERASE) ?
                               '{wr: 1'b1, addr: UNLOCK1_ADDR, data: CHIP_ERASE_CMD} :
                               '{wr: 1'b1, addr: sect, data: SECT_ERASE_CMD}; // [RL26]
               default: seq_req = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
            endcase
         end
      endcase
   endfunction : seq_req

   // ==========================================================================
   // decode
   wire logic accept = cmd_valid_i && cmd_ready_o;
   wire logic win_open = erase_act_q && !susp_q && (win_q != '0);
   wire logic erase_run = erase_act_q && !susp_q && (win_q == '0);
   wire logic op_passive = (cmd_i.op == OP_READ) || (cmd_i.op == OP_POLL);
   wire logic refuse = (erase_run && !op_passive && (cmd_i.op != OP_SUSPEND)) // [RL24]
                       || ((cmd_i.op == OP_SUSPEND) && !(erase_act_q && !susp_q))
                       || ((cmd_i.op == OP_RESUME) && !susp_q) // [RL27]
                       || ((cmd_i.op == OP_SECT_ADD) && !win_open) // [RL21]
                       || (susp_q && ((cmd_i.op == OP_CHIP_ERASE) || (cmd_i.op == OP_SECT_ERASE)));
   wire logic discard = win_open && !op_passive && (cmd_i.op != OP_SECT_ADD)
                        && (cmd_i.op != OP_SUSPEND); // [RL23]
   wire phase_t start_phase = (cmd_i.op == OP_READ) ? PH_READ :
                              (cmd_i.op == OP_POLL) ? PH_POLL1 : PH_CMD;
   wire logic [2:0] nsteps = op_steps(cmd_q.op);
   wire logic last_step = (step_q == nsteps - 3'd1);
   wire cyc_req_t exit_req = '{wr: 1'b1, addr: ANY_ADDR, data: RESET_CMD};
   wire cyc_req_t rd_req = '{wr: 1'b0, addr: cmd_q.addr, data: 8'h00};
   wire cyc_req_t cur_req = (phase_q == PH_CMD) ? seq_req(cmd_q, step_q) :
                            (phase_q == PH_EXIT) ? exit_req : rd_req;
   wire logic req_valid = (state_q == S_ISSUE);
   wire logic bus_ack;
   wire logic [7:0] bus_rdata;
   wire logic toggling = (bus_rdata[TOGGLE_BIT] != first_q[TOGGLE_BIT]);
   wire logic limit_hit = toggling && first_q[TIME_LIMIT_BIT] && bus_rdata[TIME_LIMIT_BIT];
   wire logic seq_sect = (cmd_q.op == OP_SECT_ERASE) || (cmd_q.op == OP_SECT_ADD);

   // ==========================================================================
   // sequencer
   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      step_d = step_q;
      fail_d = fail_q;
      fin = 1'b0;
      fin_err = 1'b0;
      unique case (state_q)
         S_IDLE: begin
            if (accept) begin
               fail_d = 1'b0;
               step_d = 3'd0;
               phase_d = start_phase;
               if (refuse) begin
                  fin = 1'b1;
                  fin_err = 1'b1;
               end else begin
                  state_d = S_ISSUE;
               end
            end
         end
         S_ISSUE: begin
            if (bus_ack) begin
               state_d = S_NEXT;
            end
         end
         S_NEXT: begin
            state_d = S_ISSUE;
            unique case (phase_q)
               PH_CMD: begin
                  if (!last_step) begin
                     step_d = step_q + 3'd1;
                  end else if (cmd_q.op == OP_ID_READ) begin
                     phase_d = PH_READ; // [RL13]
                  end else if ((cmd_q.op == OP_PROGRAM) || (cmd_q.op == OP_CHIP_ERASE)) begin
                     phase_d = PH_POLL1;
                  end else begin
                     state_d = S_IDLE;
                     fin = 1'b1;
                  end
               end
               PH_READ: begin
                  if (cmd_q.op == OP_ID_READ) begin
                     phase_d = PH_EXIT; // [RL11]
                  end else begin
                     state_d = S_IDLE;
                     fin = 1'b1;
                  end
               end
               PH_POLL1: phase_d = PH_POLL2;
               PH_POLL2: begin
                  if (limit_hit) begin
                     phase_d = PH_EXIT; // [RL12]
                     fail_d = 1'b1;
                  end else if (toggling) begin
                     phase_d = PH_POLL1;
                  end else begin
                     state_d = S_IDLE;
                     fin = 1'b1;
                  end
               end
               PH_EXIT: begin
                  state_d = S_IDLE;
                  fin = 1'b1;
                  fin_err = fail_q;
               end
               default: state_d = S_IDLE;
            endcase
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_q <= S_IDLE;
         phase_q <= PH_CMD;
         step_q <= 3'd0;
         fail_q <= 1'b0;
         cmd_q <= '0;
         first_q <= 8'h00;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         step_q <= step_d;
         fail_q <= fail_d;
         if (accept) begin
            cmd_q <= cmd_i;
         end
         if (bus_ack && (phase_q == PH_POLL1)) begin
            first_q <= bus_rdata;
         end
      end
   end

   // ==========================================================================
   // erase tracking and outputs
   wire logic fin_ok = fin && !fin_err && (state_q == S_NEXT);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         erase_act_q <= 1'b0;
         susp_q <= 1'b0;
         win_q <= '0;
         cmd_ready_o <= 1'b0;
         done_o <= 1'b0;
         err_o <= 1'b0;
         rdata_o <= 8'h00;
         window_open_o <= 1'b0;
         suspended_o <= 1'b0;
      end else begin
         if (win_q != '0) begin
            win_q <= win_q - WIN_W'(1);
         end
         if (accept && !refuse && discard) begin
            erase_act_q <= 1'b0; // [RL23]
            win_q <= '0;
         end
         if (fin_ok && seq_sect) begin
            erase_act_q <= 1'b1;
            win_q <= WIN_W'(SECT_WIN_CYC); // [RL22]
         end
         if (fin_ok && (cmd_q.op == OP_SUSPEND)) begin
            susp_q <= 1'b1;
            win_q <= '0;
         end
         if (fin_ok && (cmd_q.op == OP_RESUME)) begin
            susp_q <= 1'b0;
         end
         if (fin && fail_q) begin
            erase_act_q <= 1'b0;
            susp_q <= 1'b0;
         end
         if (fin_ok && (cmd_q.op == OP_POLL) && !susp_q) begin
            erase_act_q <= 1'b0;
         end
         if (bus_ack && (phase_q == PH_READ || phase_q == PH_POLL2)) begin
            rdata_o <= bus_rdata;
         end
         cmd_ready_o <= (state_d == S_IDLE) && !accept;
         done_o <= fin;
         err_o <= fin_err;
         window_open_o <= win_open;
         suspended_o <= susp_q;
      end
   end

   flash_bus_cycle u_bus (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .req_valid_i(req_valid),
      .req_i(cur_req),
      .fl_dq_i(fl_dq_i),
      .ack_o(bus_ack),
      .rdata_o(bus_rdata),
      .pins_o(fl_pins_o)
   );

   // ==========================================================================
   // checks
   a_write_oe_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RL2]
      !fl_pins_o.we_n |-> (fl_pins_o.oe_n && !fl_pins_o.ce_n && !fl_pins_o.dq_en_n))
      else $error("write strobe without select or with output enable low");
   a_unlock_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RL25]
      ($fell(fl_pins_o.we_n) && phase_q == PH_CMD && step_q == 3'd0 && nsteps > 3'd1)
      |-> (fl_pins_o.addr[10:0] == 11'h555 && fl_pins_o.dq == UNLOCK1_DATA))
      else $error("first unlock cycle wrong");
   a_program_setup: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RL26]
      ($fell(fl_pins_o.we_n) && phase_q == PH_CMD && step_q == 3'd2 && cmd_q.op == OP_PROGRAM)
      |-> fl_pins_o.dq == PROGRAM_SETUP)
      else $error("program setup byte wrong");
   a_ident_exit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RL11]
      (bus_ack && phase_q == PH_READ && cmd_q.op == OP_ID_READ)
      |-> ##2 (phase_q == PH_EXIT && cur_req.data == RESET_CMD && cur_req.wr))
      else $error("identification read not followed by reset");
   a_limit_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RL12]
      (state_q == S_NEXT && phase_q == PH_POLL2 && limit_hit) |=> phase_q == PH_EXIT ##[1:20] (done_o && err_o))
      else $error("time limit not answered by reset and error");
   a_window_refuse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RL21]
      (accept && cmd_i.op == OP_SECT_ADD && !win_open) |=> (done_o && err_o && fl_pins_o.ce_n))
      else $error("late sector add was not refused");
   a_window_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RL22]
      (fin_ok && seq_sect) |=> (win_q == WIN_W'(SECT_WIN_CYC)) ##1 $stable(erase_act_q))
      else $error("erase window not started");

   c_program: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      done_o && !err_o && cmd_q.op == OP_PROGRAM);
   c_sect_add: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      done_o && !err_o && cmd_q.op == OP_SECT_ADD);
   c_ident: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      done_o && cmd_q.op == OP_ID_READ);
   c_suspend: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(suspended_o));

endmodule : flash_host_ctrl

// >>> dv/flash_dev_model.sv
// behavioural byte-wide flash seen from its pins: command decoder, array, identification, busy polling
// assumes the host pins carrier of flash_host_pkg; read data is valid while select and output enable are low
`timescale 1ns/1ps
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter logic [7:0] MAKER = 8'h5A, // arbitrary
   parameter logic [7:0] PART = 8'hC4, // arbitrary
   parameter logic [7:0] CONT = 8'h3E, // arbitrary
   parameter logic [2:0] PROT_SECT = 3'h5,
   parameter int BUSY_READS = 3
)
(
   input flash_pins_t pins_i,
   output logic [7:0] dq_o,
   output int bad_writes_o
);
   // ==========================================================================
   // state
   logic [7:0] mem [int];
   logic [18:0] a_q;
   logic [7:0] out_q = 8'h00;
   logic [7:0] last_q = 8'h00;
   int st = 0;
   bit id_q = 0;
   bit wr_q = 0;
   bit tog_q = 0;
   int busy_n = 0;
   initial bad_writes_o = 0;
   // released bus shows the inverse of the last value
   assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? out_q : ~last_q;

   // ==========================================================================
   // write cycles
   always @(negedge pins_i.we_n or negedge pins_i.ce_n) begin
      a_q = pins_i.addr;
      wr_q = !pins_i.ce_n && !pins_i.we_n && pins_i.oe_n;
      if (!pins_i.ce_n && !pins_i.we_n && !pins_i.oe_n) bad_writes_o++;
   end
   always @(posedge pins_i.we_n or posedge pins_i.ce_n) begin
      if (wr_q) begin
         wr_q = 0;
         do_write(a_q, pins_i.dq);
      end
   end
   task automatic do_write(input logic [18:0] a, input logic [7:0] d);
      bit u1;
      bit u2;
      u1 = a[10:0] == 11'h555;
      u2 = a[10:0] == 11'h2AA && d == 8'h55;
      if (busy_n > 0) return;
      if (d == 8'hF0 && st != 3) begin
         st = 0;
         id_q = 0;
         return;
      end
      case (st)
         0: st = (u1 && d == 8'hAA) ? 1 : 0;
         1: st = u2 ? 2 : 0;
         2: begin
            st = (u1 && d == 8'hA0) ? 3 : (u1 && d == 8'h80) ? 4 : 0;
            if (u1 && d == 8'h90) id_q = 1;
         end
         3: begin
            mem[a] = (mem.exists(a) ? mem[a] : 8'hFF) & d;
            busy_n = BUSY_READS;
            st = 0;
         end
         4: st = (u1 && d == 8'hAA) ? 5 : 0;
         5: st = u2 ? 6 : 0;
         default: begin
            if (u1 && d == 8'h10) begin
               mem.delete();
               busy_n = BUSY_READS;
            end
            st = 0;
         end
      endcase
   endtask : do_write

   // ==========================================================================
   // read cycles
   always @(negedge pins_i.oe_n or negedge pins_i.ce_n) begin
      if (!pins_i.oe_n && !pins_i.ce_n) begin
         if (busy_n > 0) begin
            tog_q = !tog_q;
            busy_n--;
            out_q = {1'b0, tog_q, 6'h00};
         end else if (id_q) begin
            case (pins_i.addr[7:0])
               8'h00: out_q = MAKER;
               8'h01: out_q = PART;
               8'h03: out_q = CONT;
               default: out_q = {7'h00, pins_i.addr[18:16] == PROT_SECT};
            endcase
         end else begin
            out_q = mem.exists(pins_i.addr) ? mem[pins_i.addr] : 8'hFF;
         end
      end
   end
   always @(posedge pins_i.oe_n) last_q = out_q;
endmodule : flash_dev_model

// >>> dv/tb.sv
// self-checking bench of the flash host controller against the behavioural flash
// assumes flash_host_pkg timing constants and the command port hand-shake of flash_host_ctrl
`timescale 1ns/1ps
module tb;
   import flash_host_pkg::*;
   localparam logic [7:0] MAKER = 8'h5A; // arbitrary
   localparam logic [7:0] PART = 8'hC4; // arbitrary
   localparam logic [7:0] CONT = 8'h3E; // arbitrary
   logic sys_clk_i = 0;
   logic rst_n_i = 0;
   logic cmd_valid_i = 0;
   cmd_t cmd_i = '0;
   logic cmd_ready_o, done_o, err_o, window_open_o, suspended_o;
   logic [7:0] rdata_o, fl_dq_i;
   flash_pins_t fl_pins_o;
   int bad_writes;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic err_s;
   logic [7:0] rd_s;

   flash_host_ctrl dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .cmd_ready_o(cmd_ready_o), .done_o(done_o), .err_o(err_o), .rdata_o(rdata_o), .window_open_o(window_open_o),
      .suspended_o(suspended_o), .fl_dq_i(fl_dq_i), .fl_pins_o(fl_pins_o));
   flash_dev_model #(.MAKER(MAKER), .PART(PART), .CONT(CONT)) model_u (.pins_i(fl_pins_o), .dq_o(fl_dq_i),
      .bad_writes_o(bad_writes));

   // ==========================================================================
   // clock, timeout, helpers
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [18:0] s, input logic [18:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic run(input op_t op, input logic [18:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk_i) #1;
      cmd_valid_i = 1;
      cmd_i = '{op: op, addr: a, data: d};
      do @(negedge sys_clk_i); while (!cmd_ready_o);
      @(posedge sys_clk_i) #1;
      cmd_valid_i = 0;
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 3000);
      if (done_o !== 1'b1) fail_count++;
      err_s = err_o;
      rd_s = rdata_o;
   endtask : run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   // ==========================================================================
   // scenarios
   task automatic t_start();
      chk("idle strobes", {fl_pins_o.ce_n, fl_pins_o.we_n, fl_pins_o.oe_n, fl_pins_o.dq_en_n}, 4'hF);
      run(OP_READ, 19'h12345, 8'h00);
      chk("blank read", rd_s, 8'hFF);
      run(OP_RESET, 19'h7FFFF, 8'h00);
      chk("reset err", err_s, 1'b0);
   endtask : t_start
   task automatic t_ident();
      logic [18:0] a [5] = '{19'h1AB00, 19'h00001, 19'h7FF03, 19'h50002, 19'h10002};
      logic [7:0] e [5] = '{MAKER, PART, CONT, 8'h01, 8'h00};
      for (int i = 0; i < 5; i++) begin
         run(OP_ID_READ, a[i], 8'h00);
         chk("ident byte", rd_s, e[i]);
      end
      run(OP_READ, 19'h00001, 8'h00);
      chk("array after ident", rd_s, 8'hFF);
   endtask : t_ident
   task automatic t_program();
      run(OP_PROGRAM, 19'h12345, 8'h3C);
      chk("program err", err_s, 1'b0);
      run(OP_READ, 19'h12345, 8'h00);
      chk("programmed", rd_s, 8'h3C);
      run(OP_PROGRAM, 19'h12345, 8'hC3);
      run(OP_READ, 19'h12345, 8'h00);
      chk("zero kept", rd_s, 8'h00);
      run(OP_CHIP_ERASE, 19'h00000, 8'h00);
      run(OP_READ, 19'h12345, 8'h00);
      chk("chip erased", rd_s, 8'hFF);
   endtask : t_program
   task automatic t_refuse();
      run(OP_SUSPEND, 19'h00000, 8'h00);
      chk("suspend idle", err_s, 1'b1);
      run(OP_RESUME, 19'h00000, 8'h00);
      chk("resume idle", err_s, 1'b1);
      run(OP_SECT_ADD, 19'h30000, 8'h00);
      chk("add no window", err_s, 1'b1);
   endtask : t_refuse
   task automatic t_window();
      int n;
      run(OP_SECT_ERASE, 19'h20000, 8'h00);
      @(negedge sys_clk_i);
      chk("window open", window_open_o, 1'b1);
      run(OP_SECT_ADD, 19'h40000, 8'h00);
      chk("add in window", err_s, 1'b0);
      n = 0;
      while (window_open_o === 1'b1 && n < 4000) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk("window length", (n > SECT_WIN_CYC - 40) && (n <= SECT_WIN_CYC + 1), 1'b1);
      run(OP_SECT_ADD, 19'h50000, 8'h00);
      chk("add late", err_s, 1'b1);
      run(OP_SUSPEND, 19'h00000, 8'h00);
      @(negedge sys_clk_i);
      chk("suspended", suspended_o, 1'b1);
      run(OP_RESUME, 19'h00000, 8'h00);
      @(negedge sys_clk_i);
      chk("resumed", suspended_o, 1'b0);
      run(OP_POLL, 19'h20000, 8'h00);
      chk("poll err", err_s, 1'b0);
   endtask : t_window

   initial begin
      repeat (4) @(posedge sys_clk_i);
      #1 rst_n_i = 1;
      repeat (3) @(posedge sys_clk_i);
      t_start();
      t_ident();
      t_program();
      t_refuse();
      t_window();
      chk("write with output enable low", bad_writes, 0);
      give_verdict();
   end
endmodule : tb
